// *** design/brx_pkg.sv ***
// How it works
// - memory writes are posted into a queue
// - io and config writes retried, queued delayed
// - delayed write response stored, returned to initiator
// - all reads retried and queued as delayed
// - read completion data held, then returned
// - every write forwarded on its own
// - masked writes to one dword never merged
// - repeated writes to one address kept apart
// - order fixed only at non-retry termination
// - retried requests complete in queue order, oldest first
// - opposite directions independent, both post concurrently
// - posted acceptance never waits on mastered transactions
// - posted writes accepted despite delayed progress
// - posted writes leave in arrival order
// - delayed read waits for earlier posted writes
// - read data returned after earlier posted writes
// - delayed write never passes earlier posted writes
// - fair turns between posted and delayed queues
// - requests ordered, completions ordered, crossing allowed
package brx_pkg;
   // ------------------------------------------------------------
   // widths and depths
   // ------------------------------------------------------------
   localparam int ADDR_W = 32;
   localparam int DATA_W = 32;
   localparam int BE_W = 4;
   localparam int CNT_W = 8;
   localparam int DQ_DEPTH = 4;
   localparam int PTR_W = 2;
   localparam int PWQ_DEPTH = 16;
   // ------------------------------------------------------------
   // bus command codes
   // ------------------------------------------------------------
   localparam logic [3:0] CMD_IO_RD = 4'h2;
   localparam logic [3:0] CMD_IO_WR = 4'h3;
   localparam logic [3:0] CMD_MEM_RD = 4'h6;
   localparam logic [3:0] CMD_MEM_WR = 4'h7;
   localparam logic [3:0] CMD_CFG_RD = 4'hA;
   localparam logic [3:0] CMD_CFG_WR = 4'hB;
   localparam logic [3:0] CMD_MEM_RDM = 4'hC;
   localparam logic [3:0] CMD_MEM_RDL = 4'hE;
   localparam logic [3:0] CMD_MEM_WRI = 4'hF;

   typedef enum logic [1:0] {CL_PW, CL_DWR, CL_DRD, CL_NONE} brx_cls_t;

   // one transaction as seen on a bus
   typedef struct packed {
      logic valid;
      logic [3:0] cmd;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
      logic [BE_W-1:0] be;
   } brx_txn_t;

   // answer to an initiator attempt
   typedef struct packed {
      logic valid;
      logic retry;
      logic [DATA_W-1:0] data;
   } brx_irsp_t;

   // target-bus completion of an issued transaction
   typedef struct packed {
      logic ack;
      logic [DATA_W-1:0] data;
   } brx_trsp_t;

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   function automatic brx_cls_t brx_class(input logic [3:0] c);
      case (c)
         CMD_MEM_WR, CMD_MEM_WRI: brx_class = CL_PW;
         CMD_IO_WR, CMD_CFG_WR: brx_class = CL_DWR;
         CMD_IO_RD, CMD_MEM_RD, CMD_CFG_RD,
         CMD_MEM_RDM, CMD_MEM_RDL: brx_class = CL_DRD;
         default: brx_class = CL_NONE;
      endcase
   endfunction

   // true once out has caught up with snapshot (wrap safe)
   function automatic logic brx_drained(input logic [CNT_W-1:0] o,
                                        input logic [CNT_W-1:0] s);
      logic [CNT_W-1:0] df;
      df = o - s;
      brx_drained = !df[CNT_W-1];
   endfunction
endpackage

// *** design/brx_fifo.sv ***
`timescale 1ns/100ps
module brx_fifo #(
   parameter int W = 8,
   parameter int DEPTH = 16
) (
   input wire logic clk, // clock
   input wire logic resetn, // async reset, low
   input wire logic wr_valid, // push request
   output logic wr_ready, // room for a word
   input wire logic [W-1:0] wr_data, // pushed word
   output logic rd_valid, // head word present
   input wire logic rd_ready, // head taken
   output logic [W-1:0] rd_data // head word, registered
);
   localparam int CW = $clog2(DEPTH + 1);
   localparam int AW = $clog2(DEPTH);

   if (DEPTH < 2 || DEPTH != (1 << AW)) begin : g_chk
      $error("brx_fifo depth must be a power of two");
   end

   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [CW-1:0] cnt;
      logic ov;
      logic [W-1:0] od;
   } brx_fst_t;

   brx_fst_t r_reg, r_next;
   logic push, pop;

   assign wr_ready = r_reg.cnt != CW'(DEPTH);
   assign rd_valid = r_reg.ov;
   assign rd_data = r_reg.od;
   assign push = wr_valid && wr_ready;
   assign pop = r_reg.ov && rd_ready;

   // ------------------------------------------------------------
   // storage plus output stage; one word each, no merging
   // ------------------------------------------------------------
   always_comb begin
      r_next = r_reg;
      if (push) begin
         r_next.mem[r_reg.wp] = wr_data;
         r_next.wp = r_reg.wp + AW'(1);
      end
      if (pop) begin
         r_next.ov = 1'b0;
      end
      // refill output register strictly from the oldest word
      if ((!r_reg.ov || pop) && r_reg.cnt != '0) begin
         r_next.od = r_reg.mem[r_reg.rp];
         r_next.ov = 1'b1;
         r_next.rp = r_reg.rp + AW'(1);
      end
      r_next.cnt = r_reg.cnt + CW'(push)
                   - CW'((!r_reg.ov || pop) && r_reg.cnt != '0);
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         r_reg <= '0;
      end else begin
         r_reg <= r_next;
      end
   end
endmodule

// *** design/brx_order.sv ***
`timescale 1ns/100ps
module brx_order
   import brx_pkg::*;
#(
   parameter int PW_DEPTH = brx_pkg::PWQ_DEPTH
) (
   input wire logic clk, // 50 MHz clock
   input wire logic resetn, // async reset, low
   input brx_pkg::brx_txn_t [1:0] init_req, // attempts per side
   output brx_pkg::brx_irsp_t [1:0] init_rsp, // retry or done
   output brx_pkg::brx_txn_t [1:0] tgt_req, // forwarded op
   input brx_pkg::brx_trsp_t [1:0] tgt_rsp // target completion
);
   import brx_pkg::*;

   // counters must span far more than the queue holds
   if (PW_DEPTH < 2 || PW_DEPTH > 64) begin : g_chk
      $error("brx_order posted depth out of range");
   end

   // the posted queue only serves power-of-two depths
   if (PW_DEPTH != (1 << $clog2(PW_DEPTH))) begin : g_pow
      $error("brx_order posted depth must be a power of two");
   end

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   typedef struct packed {
      logic v;
      logic rd;
      logic issued;
      logic done;
      logic [3:0] cmd;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
      logic [BE_W-1:0] be;
      logic [DATA_W-1:0] rdata;
      logic [CNT_W-1:0] snap;
   } brx_ent_t;

   typedef struct packed {
      brx_ent_t [DQ_DEPTH-1:0] ent;
      logic [PTR_W-1:0] hd;
      logic [PTR_W-1:0] is;
      logic [PTR_W-1:0] tl;
   } brx_dq_t;

   typedef struct packed {
      brx_dq_t [1:0] dq;
      brx_irsp_t [1:0] irsp;
      brx_txn_t [1:0] treq;
      logic [1:0] tpw;
      logic [1:0] pw_turn;
      logic [1:0][PTR_W-1:0] ti;
      logic [1:0][CNT_W-1:0] pw_in;
      logic [1:0][CNT_W-1:0] pw_out;
   } brx_st_t;

   localparam int TXN_W = $bits(brx_txn_t);

   brx_st_t r_reg, r_next;
   brx_cls_t [1:0] cls;
   brx_ent_t [1:0] hd_e;
   brx_ent_t [1:0] is_e;
   logic [1:0] hit, dq_ok, pw_go, dq_go;
   logic [1:0] pw_wr_valid, pw_wr_ready, pw_rd_valid;
   brx_txn_t [1:0] pw_rd_data;

   assign init_rsp = r_reg.irsp;
   assign tgt_req = r_reg.treq;

   // a retried attempt matches its queued entry on command and address, and on data and enables for writes
   function automatic logic same(input brx_ent_t e,
                                 input brx_txn_t t);
      same = e.v && e.cmd == t.cmd && e.addr == t.addr
             && (e.rd || (e.data == t.data && e.be == t.be));
   endfunction

   // ------------------------------------------------------------
   // per direction: posted queue and decisions
   // ------------------------------------------------------------
   for (genvar d = 0; d < 2; d++) begin : g_dir
      localparam int OD = 1 - d;

      // each direction owns its posted queue
      brx_fifo #(
         .W(TXN_W),
         .DEPTH(PW_DEPTH)
      ) u_pwq (
         .clk(clk),
         .resetn(resetn),
         .wr_valid(pw_wr_valid[d]),
         .wr_ready(pw_wr_ready[d]),
         .wr_data(init_req[d]),
         .rd_valid(pw_rd_valid[d]),
         .rd_ready(pw_go[d]),
         .rd_data(pw_rd_data[d])
      );

      assign cls[d] = brx_class(init_req[d].cmd);
      assign hd_e[d] = r_reg.dq[d].ent[r_reg.dq[d].hd];
      assign is_e[d] = r_reg.dq[d].ent[r_reg.dq[d].is];

      // posted acceptance looks only at queue room
      assign pw_wr_valid[d] = init_req[d].valid && cls[d] == CL_PW;

      // oldest completion only, read data waits on the writes
      // that were queued ahead of it toward the initiator
      assign hit[d] = init_req[d].valid && cls[d] != CL_PW
                      && cls[d] != CL_NONE && hd_e[d].done
                      && same(hd_e[d], init_req[d])
                      && (!hd_e[d].rd || brx_drained(
                          r_reg.pw_out[OD], hd_e[d].snap));

      // a delayed request waits for earlier posted writes
      assign dq_ok[d] = is_e[d].v && !is_e[d].issued
                        && brx_drained(r_reg.pw_out[d],
                                       is_e[d].snap);

      // alternate turns when both queues have work
      assign pw_go[d] = !r_reg.treq[d].valid && pw_rd_valid[d]
                        && (r_reg.pw_turn[d] || !dq_ok[d]);
      assign dq_go[d] = !r_reg.treq[d].valid && dq_ok[d]
                        && !pw_go[d];
   end

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb begin
      logic seen;
      logic [PTR_W-1:0] tl;
      seen = 1'b0;
      tl = '0;
      r_next = r_reg;
      for (int d = 0; d < 2; d++) begin
         r_next.irsp[d] = '0;
         tl = r_reg.dq[d].tl;
         seen = 1'b0;
         for (int k = 0; k < DQ_DEPTH; k++) begin
            seen = seen | same(r_reg.dq[d].ent[k], init_req[d]);
         end

         // initiator side: posted, delayed or repeated attempt
         if (pw_wr_valid[d]) begin
            r_next.irsp[d].valid = 1'b1;
            // full queue is the only reason to retry a post
            r_next.irsp[d].retry = !pw_wr_ready[d];
            if (pw_wr_ready[d]) begin
               r_next.pw_in[d] = r_reg.pw_in[d] + CNT_W'(1);
            end
         end else if (hit[d]) begin
            // order fixed here, at the non-retry ending
            r_next.irsp[d].valid = 1'b1;
            r_next.irsp[d].data = hd_e[d].rdata;
            r_next.dq[d].ent[r_reg.dq[d].hd].v = 1'b0;
            r_next.dq[d].hd = r_reg.dq[d].hd + PTR_W'(1);
         end else if (init_req[d].valid && cls[d] != CL_NONE) begin
            r_next.irsp[d].valid = 1'b1;
            r_next.irsp[d].retry = 1'b1;
            // a fresh request takes the tail slot if it is free
            if (!seen && !r_reg.dq[d].ent[tl].v) begin
               r_next.dq[d].ent[tl].v = 1'b1;
               r_next.dq[d].ent[tl].rd = cls[d] == CL_DRD;
               r_next.dq[d].ent[tl].issued = 1'b0;
               r_next.dq[d].ent[tl].done = 1'b0;
               r_next.dq[d].ent[tl].cmd = init_req[d].cmd;
               r_next.dq[d].ent[tl].addr = init_req[d].addr;
               r_next.dq[d].ent[tl].data = init_req[d].data;
               r_next.dq[d].ent[tl].be = init_req[d].be;
               r_next.dq[d].ent[tl].rdata = '0;
               r_next.dq[d].ent[tl].snap = r_reg.pw_in[d];
               r_next.dq[d].tl = tl + PTR_W'(1);
            end
         end

         // target side: one operation outstanding at a time
         if (r_reg.treq[d].valid && tgt_rsp[d].ack) begin
            r_next.treq[d].valid = 1'b0;
            if (r_reg.tpw[d]) begin
               r_next.pw_out[d] = r_reg.pw_out[d] + CNT_W'(1);
            end else begin
               r_next.dq[d].ent[r_reg.ti[d]].done = 1'b1;
               r_next.dq[d].ent[r_reg.ti[d]].rdata = tgt_rsp[d].data;
               // completion data travels the other way
               r_next.dq[d].ent[r_reg.ti[d]].snap =
                  r_reg.pw_in[d ^ 1];
            end
         end else if (pw_go[d]) begin
            r_next.treq[d] = pw_rd_data[d];
            r_next.treq[d].valid = 1'b1;
            r_next.tpw[d] = 1'b1;
            r_next.pw_turn[d] = 1'b0;
         end else if (dq_go[d]) begin
            r_next.treq[d].valid = 1'b1;
            r_next.treq[d].cmd = is_e[d].cmd;
            r_next.treq[d].addr = is_e[d].addr;
            r_next.treq[d].data = is_e[d].data;
            r_next.treq[d].be = is_e[d].be;
            r_next.tpw[d] = 1'b0;
            r_next.pw_turn[d] = 1'b1;
            r_next.ti[d] = r_reg.dq[d].is;
            r_next.dq[d].ent[r_reg.dq[d].is].issued = 1'b1;
            r_next.dq[d].is = r_reg.dq[d].is + PTR_W'(1);
         end
      end
   end

   // ------------------------------------------------------------
   // state register
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         r_reg <= '0;
      end else begin
         r_reg <= r_next;
      end
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!resetn);

   for (genvar d = 0; d < 2; d++) begin : g_chk_dir
      localparam int OD = 1 - d;

      a_pw_accept: assert property (
         pw_wr_valid[d] && pw_wr_ready[d]
         |=> init_rsp[d].valid && !init_rsp[d].retry
             && r_reg.pw_in[d] == $past(r_reg.pw_in[d]) + 8'h01)
         else $error("posted write not accepted");

      a_dly_retry: assert property (
         init_req[d].valid && cls[d] != CL_PW
         && cls[d] != CL_NONE && !hit[d]
         |=> init_rsp[d].valid && init_rsp[d].retry)
         else $error("delayed request not retried");

      a_cpl_return: assert property (
         hit[d]
         |-> (!hd_e[d].rd
              || brx_drained(r_reg.pw_out[OD], hd_e[d].snap))
         ##1 init_rsp[d].valid && !init_rsp[d].retry
             && init_rsp[d].data == $past(hd_e[d].rdata))
         else $error("completion returned too early");

      a_dly_drain: assert property (
         $rose(tgt_req[d].valid) && !r_reg.tpw[d]
         |-> brx_drained(r_reg.pw_out[d],
                         r_reg.dq[d].ent[r_reg.ti[d]].snap))
         else $error("delayed request passed posted write");

      a_pw_bound: assert property (
         (r_reg.pw_in[d] - r_reg.pw_out[d]) <= 8'(PW_DEPTH + 2))
         else $error("posted counters out of step");

      a_pw_step: assert property (
         tgt_req[d].valid && tgt_rsp[d].ack && r_reg.tpw[d]
         |=> !tgt_req[d].valid
             && r_reg.pw_out[d] == $past(r_reg.pw_out[d]) + 8'h01)
         else $error("posted completion miscounted");

      a_tgt_hold: assert property (
         tgt_req[d].valid && !tgt_rsp[d].ack
         |=> tgt_req[d].valid && $stable(tgt_req[d]))
         else $error("target request changed early");

      a_fair_turn: assert property (
         dq_go[d] && pw_rd_valid[d]
         |=> r_reg.pw_turn[d] [*1] ##0 !r_reg.tpw[d])
         else $error("posted queue lost its turn");

      a_dq_order: assert property (
         dq_go[d]
         |=> r_reg.ti[d] == $past(r_reg.dq[d].is)
             && r_reg.dq[d].is == $past(r_reg.dq[d].is) + 2'b01)
         else $error("delayed requests issued out of order");

      // retry answers leave the queue order untouched
      a_pw_full_retry: assert property (
         pw_wr_valid[d] && !pw_wr_ready[d]
         |=> init_rsp[d].valid && init_rsp[d].retry
             && r_reg.pw_in[d] == $past(r_reg.pw_in[d]))
         else $error("full posted queue not retried");

      a_retry_keep: assert property (
         init_rsp[d].valid && init_rsp[d].retry
         |-> r_reg.dq[d].hd == $past(r_reg.dq[d].hd))
         else $error("retried attempt moved the order");

      a_done_release: assert property (
         hit[d]
         |=> r_reg.dq[d].hd == $past(r_reg.dq[d].hd) + PTR_W'(1))
         else $error("released completion kept its slot");

      a_rsp_cause: assert property (
         init_rsp[d].valid |-> $past(init_req[d].valid))
         else $error("answer without an attempt");

      // target side: stored responses and posted bookkeeping
      a_cpl_store: assert property (
         tgt_req[d].valid && tgt_rsp[d].ack && !r_reg.tpw[d]
         |=> r_reg.dq[d].ent[r_reg.ti[d]].done
             && r_reg.dq[d].ent[r_reg.ti[d]].rdata
                == $past(tgt_rsp[d].data))
         else $error("target response not stored");

      a_dwr_cpl: assert property (
         hit[d] && !hd_e[d].rd
         |-> hd_e[d].issued
         ##1 init_rsp[d].valid && !init_rsp[d].retry)
         else $error("write completion before target");

      a_tgt_gap: assert property (
         tgt_req[d].valid && tgt_rsp[d].ack |=> !tgt_req[d].valid)
         else $error("target op not retired after ack");

      a_pw_issue: assert property (
         pw_go[d]
         |=> tgt_req[d].valid && r_reg.tpw[d]
             && tgt_req[d].addr == $past(pw_rd_data[d].addr))
         else $error("posted head not forwarded");

      a_pw_once: assert property (
         !(tgt_req[d].valid && tgt_rsp[d].ack && r_reg.tpw[d])
         |=> r_reg.pw_out[d] == $past(r_reg.pw_out[d]))
         else $error("posted write counted twice");

      a_dwr_wait: assert property (
         dq_go[d] && !is_e[d].rd
         |-> brx_drained(r_reg.pw_out[d], is_e[d].snap))
         else $error("delayed write passed posted write");

      a_pw_yield: assert property (
         pw_go[d] |=> !r_reg.pw_turn[d])
         else $error("posted queue kept its turn");
   end

   // posted writes taken both ways in one cycle
   a_both_post: assert property (
      pw_wr_valid[0] && pw_wr_ready[0] && pw_wr_valid[1] && pw_wr_ready[1]
      |=> init_rsp[0].valid && !init_rsp[0].retry
          && init_rsp[1].valid && !init_rsp[1].retry)
      else $error("posts in both directions not taken together");
endmodule

// *** bench/brx_tgt_model.sv ***
`timescale 1ns/100ps
module brx_tgt_model
   import brx_pkg::*;
(
   input wire logic clk, // clock
   input wire logic resetn, // async reset, low
   input brx_pkg::brx_txn_t [1:0] tgt_req, // ops from the bridge
   input wire logic [1:0] stall, // hold acks back while set
   output brx_pkg::brx_trsp_t [1:0] tgt_rsp // acks and read data
);
   int seed = 32'h9e19;
   // ------------------------------------------------------------
   // target per direction
   // ------------------------------------------------------------
   // random ack wait; data is noise outside the ack so a late read of
   // it by the bridge shows up as garbage instead of a stale value
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         tgt_rsp <= '0;
      end else begin
         for (int d = 0; d < 2; d++) begin
            if (tgt_rsp[d].ack) begin
               tgt_rsp[d] <= #1 '{1'b0, 32'($random(seed))};
            end else if (tgt_req[d].valid && !stall[d] &&
                         ($random(seed) & 3) != 3) begin
               // any op acked when not stalled and the draw passes; data from its address
               tgt_rsp[d] <= #1 '{1'b1, tgt_req[d].addr ^ 32'hC3A5_5A3C};
            end else begin
               tgt_rsp[d] <= #1 '{1'b0, 32'($random(seed))};
            end
         end
      end
   end
endmodule

// *** bench/tb.sv ***
`timescale 1ns/100ps
module tb;
   import brx_pkg::*;
   localparam int PWD = 16;
   localparam logic [3:0] DCMD [7] = '{CMD_IO_RD, CMD_MEM_RD, CMD_CFG_RD,
      CMD_MEM_RDM, CMD_MEM_RDL, CMD_IO_WR, CMD_CFG_WR};
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic [1:0] stall = 2'h0;
   brx_txn_t [1:0] init_req = '0;
   brx_irsp_t [1:0] init_rsp;
   brx_txn_t [1:0] tgt_req;
   brx_trsp_t [1:0] tgt_rsp;
   int err_count = 0;
   int check_count = 0;
   int seed = 32'h9e19;
   int ack_cnt [2] = '{0, 0};
   int push_cnt [2] = '{0, 0};
   brx_txn_t exp_q [2][$];

   brx_order #(.PW_DEPTH(PWD)) brx_order_i (.clk(clk), .resetn(resetn),
      .init_req(init_req), .init_rsp(init_rsp), .tgt_req(tgt_req),
      .tgt_rsp(tgt_rsp));
   brx_tgt_model brx_tgt_model_i (.clk(clk), .resetn(resetn),
      .tgt_req(tgt_req), .stall(stall), .tgt_rsp(tgt_rsp));

   // 50 MHz clock
   always #10 clk = ~clk;

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   task automatic close_out();
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   task automatic check(input logic ok, input string msg);
      check_count++;
      if (ok !== 1'b1) begin
         err_count++;
         $display("mismatch at %0t: %s", $time, msg);
      end
   endtask

   function automatic logic rd_cmd(input logic [3:0] c);
      rd_cmd = c inside {CMD_IO_RD, CMD_MEM_RD, CMD_CFG_RD, CMD_MEM_RDM,
                         CMD_MEM_RDL};
   endfunction

   // small address pool, so repeats and masked writes to one dword occur
   function automatic brx_txn_t rnd_pw();
      rnd_pw.valid = 1'b1;
      rnd_pw.cmd = ($random(seed) & 1) ? CMD_MEM_WRI : CMD_MEM_WR;
      rnd_pw.addr = 32'h0000_1000 + 32'(($random(seed) & 3) << 2);
      rnd_pw.data = 32'($random(seed));
      rnd_pw.be = 4'($random(seed));
   endfunction

   task automatic exp_add(input int d, input brx_txn_t t);
      exp_q[d].push_back(t);
      push_cnt[d]++;
   endtask

   // one attempt: valid for one cycle, answer looked at the cycle after
   task automatic att(input int d, input brx_txn_t t, output brx_irsp_t r);
      @(posedge clk) #1;
      init_req[d] = t;
      @(posedge clk) #1;
      init_req[d].valid = 1'b0;
      r = init_rsp[d];
   endtask

   task automatic post(input int d, input brx_txn_t t);
      brx_irsp_t r;
      int n;
      n = 0;
      do begin
         att(d, t, r);
         check(r.valid, "posted write unanswered");
         n++;
      end while (r.retry === 1'b1 && n < 100);
      check(r.retry === 1'b0, "posted write never taken");
      exp_add(d, t);
   endtask

   task automatic dq(input int d, input brx_txn_t t, output int idx);
      brx_irsp_t r;
      att(d, t, r);
      check(r.valid && r.retry, "first try not retried");
      idx = push_cnt[d];
      exp_add(d, t);
   endtask

   task automatic dtry(input int d, input brx_txn_t t, input int idx,
                       output logic dn);
      brx_irsp_t r;
      att(d, t, r);
      check(r.valid, "delayed retry unanswered");
      dn = r.valid === 1'b1 && r.retry === 1'b0;
      if (dn) begin
         check(ack_cnt[d] > idx, "done before target");
         if (rd_cmd(t.cmd)) begin
            check(r.data === (t.addr ^ 32'hC3A5_5A3C), "read data");
         end
      end
   endtask

   task automatic dfin(input int d, input brx_txn_t t, input int idx);
      logic dn;
      dn = 1'b0;
      for (int k = 0; k < 400 && !dn; k++) dtry(d, t, idx, dn);
      check(dn, "delayed op never completed");
   endtask

   task automatic drain(input string name);
      for (int k = 0; k < 2000 && exp_q[0].size() + exp_q[1].size(); k++)
         @(posedge clk);
      check(exp_q[0].size() + exp_q[1].size() == 0, "op lost");
      $display("test %s done", name);
   endtask

   // ------------------------------------------------------------
   // target bus scoreboard
   // ------------------------------------------------------------
   // each op must match the oldest expected one: no merge, no reorder
   always @(posedge clk) begin : mon
      brx_txn_t e;
      brx_txn_t q;
      logic ok;
      for (int d = 0; d < 2; d++) begin
         if (tgt_req[d].valid === 1'b1 && tgt_rsp[d].ack === 1'b1) begin
            q = tgt_req[d];
            e = exp_q[d].size() ? exp_q[d].pop_front() : '0;
            ok = e.valid === 1'b1 && q.cmd === e.cmd && q.addr === e.addr;
            if (!rd_cmd(e.cmd)) ok = ok && q.data === e.data && q.be === e.be;
            check(ok, "target op order");
            ack_cnt[d]++;
         end
      end
   end

   // hang guard, far above the expected run length
   initial begin
      #(20 * 40000);
      err_count++;
      $display("mismatch at %0t: watchdog expired", $time);
      close_out();
   end

   initial begin
      brx_txn_t t0;
      brx_txn_t t1;
      brx_irsp_t r;
      int ix0;
      int ix1;
      int n;
      logic dn0;
      logic dn1;
      repeat (16) @(posedge clk);
      #1 resetn = 1'b1;
      // posted traffic both ways at once, every delayed kind in between
      for (int i = 0; i < 56; i++) begin
         t0 = rnd_pw();
         t1 = rnd_pw();
         fork
            post(0, t0);
            post(1, t1);
         join
         if (i % 8 == 7) begin
            t0 = rnd_pw();
            t0.cmd = DCMD[i / 8];
            dq((i / 8) % 2, t0, ix0);
            dfin((i / 8) % 2, t0, ix0);
         end
      end
      drain("mixed");
      // read data held back behind opposite-way posted writes
      stall = 2'h2;
      post(1, rnd_pw());
      post(1, rnd_pw());
      t0 = rnd_pw();
      t0.cmd = CMD_MEM_RD;
      dq(0, t0, ix0);
      for (int k = 0; k < 60 && ack_cnt[0] <= ix0; k++) @(posedge clk);
      check(ack_cnt[0] > ix0, "read not forwarded");
      for (int k = 0; k < 6; k++) begin
         dtry(0, t0, ix0, dn0);
         check(!dn0, "read data passed writes");
      end
      stall = 2'h0;
      dfin(0, t0, ix0);
      check(ack_cnt[1] == push_cnt[1], "writes not flushed");
      drain("read_pull");
      // fill the posted queue behind a delayed write that itself
      // waits on one earlier posted write held at the target
      stall = 2'h1;
      post(0, rnd_pw());
      t0 = rnd_pw();
      t0.cmd = CMD_CFG_WR;
      dq(0, t0, ix0);
      n = 0;
      for (int k = 0; k < PWD + 4; k++) begin
         t1 = rnd_pw();
         att(0, t1, r);
         if (r.retry !== 1'b0) break;
         exp_add(0, t1);
         n++;
      end
      check(n == PWD + 1, "posted queue depth");
      t1 = rnd_pw();
      att(1, t1, r);
      check(r.valid && !r.retry, "other way refused");
      exp_add(1, t1);
      stall = 2'h0;
      dfin(0, t0, ix0);
      drain("fill");
      // two reads outstanding, retried in turn
      t0 = rnd_pw();
      t0.cmd = CMD_IO_RD;
      t1 = rnd_pw();
      t1.cmd = CMD_MEM_RDL;
      t1.addr = t1.addr + 32'h0000_0100;
      dq(0, t0, ix0);
      dq(0, t1, ix1);
      dn0 = 1'b0;
      dn1 = 1'b0;
      for (int k = 0; k < 300 && !(dn0 && dn1); k++) begin
         if (!dn0) dtry(0, t0, ix0, dn0);
         if (!dn1) dtry(0, t1, ix1, dn1);
      end
      check(dn0 && dn1, "reads not both done");
      drain("two_reads");
      close_out();
   end
endmodule
